//--- mba_pkg.sv
package mba_pkg;

    // ****************************************************
    // register map (byte addresses on apb)
    // ****************************************************
    localparam logic [7:0] ADDR_CIRC_CTRL = 8'h00;
    localparam logic [7:0] ADDR_REV_CTRL = 8'h04;
    localparam logic [7:0] ADDR_XMOD_START = 8'h08;
    localparam logic [7:0] ADDR_XMOD_END = 8'h0c;
    localparam logic [7:0] ADDR_YMOD_START = 8'h10;
    localparam logic [7:0] ADDR_YMOD_END = 8'h14;
    localparam logic [7:0] ADDR_STATUS = 8'h18;

    // ****************************************************
    // fields
    // ****************************************************
    localparam int XMOD_EN_BIT = 15;
    localparam int YMOD_EN_BIT = 14;
    localparam int REV_SEL_LSB = 8;
    localparam int XMOD_SEL_LSB = 0;
    localparam int YMOD_SEL_LSB = 4;
    localparam int REV_EN_BIT = 15;
    localparam int REV_MOD_W = 15;
    localparam logic [3:0] STACK_PTR_SEL = 4'hf;
    localparam logic [15:0] CIRC_CTRL_RESET = 16'h0000;
    localparam logic [15:0] REV_CTRL_RESET = 16'h0000;
    localparam logic [15:0] ADDR_RESET = 16'h0000;

    // ****************************************************
    // addressing modes of one access
    // ****************************************************
    typedef enum logic [2:0] {
        MBA_AM_DIRECT,
        MBA_AM_POST_INC,
        MBA_AM_POST_DEC,
        MBA_AM_PRE_INC,
        MBA_AM_PRE_DEC,
        MBA_AM_OFFSET
    } mba_amode_e;

endpackage

//--- mba_agu.sv
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps

// Behaviour
// - circular correction may use any working register as pointer
// - wrap check uses greater-than and less-than, not equality
// - corrected address written back only for pre or post modify
// - register plus offset mode corrects address but keeps pointer
// - bit reversal only in x write generator, only for writes
// - pointer and modifier both bit reversed for the add, then reversed back; pointer kept in normal order
// - reversal needs select not 15, enable set, pre/post increment
// - reverse modifier is 15-bit field of reverse control register
// - reversal assumes words: lsb forced zero, modifier scaled
// - byte writes and other modes get normal addresses
// - reversal adds modifier and ignores the mode's own increment
// - reversal wins over circular in write path; read keeps it
module mba_agu
    import mba_pkg::*;
#(
    parameter int NREG = 16
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rd_req,
    input wire logic [3:0] rd_reg,
    input wire mba_amode_e rd_mode,
    input wire logic [15:0] rd_ptr,
    input wire logic [15:0] rd_ofs,
    input wire logic rd_byte,
    input wire logic wr_req,
    input wire logic [3:0] wr_reg,
    input wire mba_amode_e wr_mode,
    input wire logic [15:0] wr_ptr,
    input wire logic [15:0] wr_ofs,
    input wire logic wr_byte,
    output logic rd_ea_valid,
    output logic [15:0] rd_ea,
    output logic rd_wb,
    output logic [3:0] rd_wb_reg,
    output logic [15:0] rd_wb_val,
    output logic wr_ea_valid,
    output logic [15:0] wr_ea,
    output logic wr_wb,
    output logic [3:0] wr_wb_reg,
    output logic [15:0] wr_wb_val,
    output logic wr_rev_used
);

    // ****************************************************
    // helpers
    // ****************************************************
    typedef struct packed {
        logic [15:0] ea;
        logic [15:0] wb;
        logic wbe;
    } mba_res_s;

    function automatic logic [15:0] rev16(input logic [15:0] v);
        logic [15:0] r;
        r = '0;
        for (int i = 0; i < 16; i++) begin
            r[i] = v[15 - i];
        end
        return r;
    endfunction

    // reverse-carry add: reverse both, add, reverse back
    function automatic logic [15:0] rev_add(
        input logic [15:0] p,
        input logic [15:0] m
    );
        logic [15:0] s;
        s = rev16(p) + rev16(m);
        return rev16(s);
    endfunction

    // circular correction with inequality bounds
    function automatic logic [15:0] wrap(
        input logic [15:0] a,
        input logic [15:0] lo,
        input logic [15:0] hi,
        input logic dec
    );
        logic [15:0] len;
        len = 16'(hi - lo + 16'h0001);
        if (!dec && a > hi) begin
            return 16'(a - len);
        end else if (dec && a < lo) begin
            return 16'(a + len);
        end
        return a;
    endfunction

    // one address generation
    function automatic mba_res_s gen(
        input mba_amode_e md,
        input logic [15:0] p,
        input logic [15:0] o,
        input logic byt,
        input logic circ,
        input logic [15:0] lo,
        input logic [15:0] hi,
        input logic rev,
        input logic [14:0] rmod
    );
        mba_res_s r;
        logic [15:0] step;
        logic [15:0] nxt;
        logic [15:0] m;
        logic dec;
        r = '0;
        nxt = '0;
        step = byt ? 16'h0001 : 16'h0002;
        dec = (md == MBA_AM_POST_DEC) || (md == MBA_AM_PRE_DEC);
        m = {rmod, 1'b0}; // modifier scaled to bytes
        unique case (md)
            MBA_AM_DIRECT: begin
                r.ea = p;
            end
            MBA_AM_OFFSET: begin
                r.ea = 16'(p + o);
                if (circ) begin
                    r.ea = wrap(r.ea, lo, hi, 1'b0);
                end
            end
            default: begin
                if (rev) begin
                    // normal-order pointer and modifier; rev_add reverses both
                    nxt = rev_add(p, m);
                    nxt[0] = 1'b0;
                end else begin
                    nxt = dec ? 16'(p - step) : 16'(p + step);
                    if (circ) begin
                        nxt = wrap(nxt, lo, hi, dec);
                    end
                end
                if (md == MBA_AM_PRE_INC || md == MBA_AM_PRE_DEC) begin
                    r.ea = nxt;
                end else begin
                    r.ea = p;
                end
                if (rev) begin
                    r.ea[0] = 1'b0;
                end
                r.wb = nxt;
                r.wbe = 1'b1;
            end
        endcase
        return r;
    endfunction

    // ****************************************************
    // state
    // ****************************************************
    typedef struct packed {
        logic [15:0] circ_ctrl;
        logic [15:0] rev_ctrl;
        logic [15:0] xs;
        logic [15:0] xe;
        logic [15:0] ys;
        logic [15:0] ye;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic rd_ea_valid;
        logic [15:0] rd_ea;
        logic rd_wb;
        logic [3:0] rd_wb_reg;
        logic [15:0] rd_wb_val;
        logic wr_ea_valid;
        logic [15:0] wr_ea;
        logic wr_wb;
        logic [3:0] wr_wb_reg;
        logic [15:0] wr_wb_val;
        logic wr_rev_used;
    } mba_state_s;

    mba_state_s st;
    mba_state_s next_st;

    logic rev_on;
    logic rd_circ;
    logic wr_circ;
    logic wr_rev;
    mba_res_s rres;
    mba_res_s wres;

    function automatic logic circ_hit(
        input logic [15:0] cc,
        input logic [3:0] rg
    );
        return (cc[XMOD_EN_BIT] && cc[XMOD_SEL_LSB +: 4] == rg) ||
            (cc[YMOD_EN_BIT] && cc[YMOD_SEL_LSB +: 4] == rg);
    endfunction

    function automatic logic [15:0] bound(
        input logic [15:0] cc,
        input logic [3:0] rg,
        input logic [15:0] xv,
        input logic [15:0] yv
    );
        return (cc[XMOD_EN_BIT] && cc[XMOD_SEL_LSB +: 4] == rg) ? xv : yv;
    endfunction

    // ****************************************************
    // next state
    // ****************************************************
    always_comb begin
        next_st = st;
        // enable only off the stack pointer
        rev_on = st.rev_ctrl[REV_EN_BIT] &&
            (st.circ_ctrl[REV_SEL_LSB +: 4] != STACK_PTR_SEL);
        wr_rev = rev_on && !wr_byte &&
            (wr_reg == st.circ_ctrl[REV_SEL_LSB +: 4]) &&
            (wr_mode == MBA_AM_PRE_INC ||
             wr_mode == MBA_AM_POST_INC);
        rd_circ = circ_hit(st.circ_ctrl, rd_reg);
        wr_circ = circ_hit(st.circ_ctrl, wr_reg) && !wr_rev;
        // read path never reverses
        rres = gen(rd_mode, rd_ptr, rd_ofs, rd_byte, rd_circ,
            bound(st.circ_ctrl, rd_reg, st.xs, st.ys),
            bound(st.circ_ctrl, rd_reg, st.xe, st.ye),
            1'b0, st.rev_ctrl[REV_MOD_W-1:0]);
        wres = gen(wr_mode, wr_ptr, wr_ofs, wr_byte, wr_circ,
            bound(st.circ_ctrl, wr_reg, st.xs, st.ys),
            bound(st.circ_ctrl, wr_reg, st.xe, st.ye),
            wr_rev, st.rev_ctrl[REV_MOD_W-1:0]);

        next_st.rd_ea_valid = rd_req;
        next_st.rd_ea = rres.ea;
        next_st.rd_wb = rd_req && rres.wbe;
        next_st.rd_wb_reg = rd_reg;
        next_st.rd_wb_val = rres.wb;
        next_st.wr_ea_valid = wr_req;
        next_st.wr_ea = wres.ea;
        next_st.wr_wb = wr_req && wres.wbe;
        next_st.wr_wb_reg = wr_reg;
        next_st.wr_wb_val = wres.wb;
        next_st.wr_rev_used = wr_req && wr_rev;

        // apb slave, one wait state
        next_st.pready = 1'b0;
        next_st.pslverr = 1'b0;
        if (psel && penable && !st.pready) begin
            next_st.pready = 1'b1;
            next_st.prdata = '0;
            unique case (paddr)
                ADDR_CIRC_CTRL: begin
                    next_st.prdata = {16'h0000, st.circ_ctrl};
                    if (pwrite) next_st.circ_ctrl = pwdata[15:0];
                end
                ADDR_REV_CTRL: begin
                    next_st.prdata = {16'h0000, st.rev_ctrl};
                    if (pwrite) next_st.rev_ctrl = pwdata[15:0];
                end
                ADDR_XMOD_START: begin
                    next_st.prdata = {16'h0000, st.xs};
                    if (pwrite) next_st.xs = pwdata[15:0];
                end
                ADDR_XMOD_END: begin
                    next_st.prdata = {16'h0000, st.xe};
                    if (pwrite) next_st.xe = pwdata[15:0];
                end
                ADDR_YMOD_START: begin
                    next_st.prdata = {16'h0000, st.ys};
                    if (pwrite) next_st.ys = pwdata[15:0];
                end
                ADDR_YMOD_END: begin
                    next_st.prdata = {16'h0000, st.ye};
                    if (pwrite) next_st.ye = pwdata[15:0];
                end
                ADDR_STATUS: begin
                    next_st.prdata = {29'h0000_0000, rev_on,
                        st.circ_ctrl[XMOD_EN_BIT] && !rev_on,
                        st.circ_ctrl[YMOD_EN_BIT]};
                    next_st.pslverr = pwrite;
                end
                default: begin
                    next_st.pslverr = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            st <= '0;
            st.circ_ctrl <= CIRC_CTRL_RESET;
            st.rev_ctrl <= REV_CTRL_RESET;
            st.xs <= ADDR_RESET;
            st.xe <= ADDR_RESET;
            st.ys <= ADDR_RESET;
            st.ye <= ADDR_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = st.pslverr;
    assign rd_ea_valid = st.rd_ea_valid;
    assign rd_ea = st.rd_ea;
    assign rd_wb = st.rd_wb;
    assign rd_wb_reg = st.rd_wb_reg;
    assign rd_wb_val = st.rd_wb_val;
    assign wr_ea_valid = st.wr_ea_valid;
    assign wr_ea = st.wr_ea;
    assign wr_wb = st.wr_wb;
    assign wr_wb_reg = st.wr_wb_reg;
    assign wr_wb_val = st.wr_wb_val;
    assign wr_rev_used = st.wr_rev_used;

endmodule // mba_agu

//--- mba_agu_sva.sv
`timescale 1ns/1ps
// ****************
// port checker
// ****************
module mba_agu_sva
    import mba_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic rd_req,
    input wire mba_amode_e rd_mode,
    input wire logic [15:0] rd_ptr,
    input wire logic [15:0] rd_ea,
    input wire logic rd_wb,
    input wire logic [15:0] rd_wb_val,
    input wire logic wr_req,
    input wire logic [3:0] wr_reg,
    input wire mba_amode_e wr_mode,
    input wire logic wr_byte,
    input wire logic [15:0] wr_ea,
    input wire logic wr_wb,
    input wire logic [15:0] wr_wb_val,
    input wire logic wr_rev_used
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    a_pready_next: assert property (psel && penable && !pready |=> pready)
        else $error("pready late");
    a_err_qual: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_direct_ea: assert property (
        rd_req && rd_mode == MBA_AM_DIRECT
        |=> !rd_wb && rd_ea == $past(rd_ptr))
        else $error("direct address wrong");
    a_post_ea: assert property (
        rd_req && rd_mode inside {MBA_AM_POST_INC, MBA_AM_POST_DEC}
        |=> rd_wb && rd_ea == $past(rd_ptr)) else $error("post address wrong");
    a_pre_ea: assert property (
        rd_req && rd_mode inside {MBA_AM_PRE_INC, MBA_AM_PRE_DEC}
        |=> rd_wb && rd_ea == rd_wb_val) else $error("pre address wrong");
    a_offset_keep: assert property (
        wr_req && wr_mode == MBA_AM_OFFSET |=> !wr_wb && !wr_rev_used)
        else $error("offset mode wrote back");
    a_rev_cause: assert property (
        wr_rev_used |-> $past(wr_req && !wr_byte
        && wr_reg != STACK_PTR_SEL
        && wr_mode inside {MBA_AM_PRE_INC, MBA_AM_POST_INC}))
        else $error("reversal without cause");
    a_rev_word: assert property (
        wr_rev_used |-> wr_wb && !wr_ea[0] && !wr_wb_val[0])
        else $error("reversed address odd");
    c_rev: cover property (wr_rev_used);
    c_err: cover property (pslverr);
    c_rd_wb: cover property (rd_wb);
    c_offset: cover property (wr_req && wr_mode == MBA_AM_OFFSET);
endmodule // mba_agu_sva
bind mba_agu mba_agu_sva u_mba_agu_sva (
    .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .rd_req(rd_req),
    .rd_mode(rd_mode), .rd_ptr(rd_ptr), .rd_ea(rd_ea), .rd_wb(rd_wb),
    .rd_wb_val(rd_wb_val), .wr_req(wr_req), .wr_reg(wr_reg),
    .wr_mode(wr_mode), .wr_byte(wr_byte), .wr_ea(wr_ea), .wr_wb(wr_wb),
    .wr_wb_val(wr_wb_val), .wr_rev_used(wr_rev_used)
);

//--- mba_core.sv
`timescale 1ns/1ps
// ****************
// core pointer file
// ****************
module mba_core
    import mba_pkg::*;
(
    input wire logic clk_sys,
    input wire logic [3:0] sel,
    input wire logic ld,
    input wire logic [3:0] ld_reg,
    input wire logic [15:0] ld_val,
    input wire logic rd_wb,
    input wire logic [3:0] rd_wb_reg,
    input wire logic [15:0] rd_wb_val,
    input wire logic wr_wb,
    input wire logic [3:0] wr_wb_reg,
    input wire logic [15:0] wr_wb_val,
    output logic [15:0] ptr
);
    logic [15:0] w [16];
    assign ptr = w[sel];
    always_ff @(posedge clk_sys) begin
        if (ld) begin
            w[ld_reg] <= ld_val;
        end
        if (rd_wb) begin
            w[rd_wb_reg] <= rd_wb_val;
        end
        if (wr_wb) begin
            w[wr_wb_reg] <= wr_wb_val;
        end
    end
endmodule // mba_core

//--- tb.sv
`timescale 1ns/1ps
module tb
    import mba_pkg::*;
;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic rd_req = 1'b0;
    logic wr_req = 1'b0;
    logic [3:0] q_reg = 4'h0;
    mba_amode_e q_mode = MBA_AM_DIRECT;
    logic [15:0] q_ofs = 16'h0000;
    logic q_byte = 1'b0;
    logic ld = 1'b0;
    logic [3:0] ld_reg = 4'h0;
    logic [15:0] ld_val = 16'h0000;
    logic pready, pslverr, err, rd_ea_valid, rd_wb, wr_ea_valid, wr_wb;
    logic wr_rev_used;
    logic [3:0] rd_wb_reg, wr_wb_reg;
    logic [15:0] ptr, rd_ea, rd_wb_val, wr_ea, wr_wb_val;
    logic [31:0] prdata, rdat;
    int failures = 0;
    int checks_done = 0;
    always #5 clk_sys = ~clk_sys;
    mba_agu u_mba_agu (
        .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rd_req(rd_req),
        .rd_reg(q_reg), .rd_mode(q_mode), .rd_ptr(ptr), .rd_ofs(q_ofs),
        .rd_byte(q_byte), .wr_req(wr_req), .wr_reg(q_reg), .wr_mode(q_mode),
        .wr_ptr(ptr), .wr_ofs(q_ofs), .wr_byte(q_byte),
        .rd_ea_valid(rd_ea_valid), .rd_ea(rd_ea), .rd_wb(rd_wb),
        .rd_wb_reg(rd_wb_reg), .rd_wb_val(rd_wb_val),
        .wr_ea_valid(wr_ea_valid), .wr_ea(wr_ea), .wr_wb(wr_wb),
        .wr_wb_reg(wr_wb_reg), .wr_wb_val(wr_wb_val),
        .wr_rev_used(wr_rev_used)
    );
    mba_core u_mba_core (
        .clk_sys(clk_sys), .sel(q_reg), .ld(ld), .ld_reg(ld_reg),
        .ld_val(ld_val), .rd_wb(rd_wb), .rd_wb_reg(rd_wb_reg),
        .rd_wb_val(rd_wb_val), .wr_wb(wr_wb), .wr_wb_reg(wr_wb_reg),
        .wr_wb_val(wr_wb_val), .ptr(ptr)
    );
    // ****************
    // tasks
    // ****************
    task automatic chk(input string n, input logic [31:0] s, e);
        checks_done++;
        if (s !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic load(input int r, input logic [15:0] v);
        @(posedge clk_sys);
        ld <= 1'b1;
        ld_reg <= 4'(r);
        ld_val <= v;
        @(posedge clk_sys);
        ld <= 1'b0;
    endtask
    task automatic go(input int w, input int r, input mba_amode_e m,
        input int o, input int b, input logic [15:0] e, v, input int rv);
        @(posedge clk_sys);
        rd_req <= (w == 0);
        wr_req <= (w != 0);
        q_reg <= 4'(r);
        q_mode <= m;
        q_ofs <= 16'(o);
        q_byte <= (b != 0);
        @(posedge clk_sys);
        rd_req <= 1'b0;
        wr_req <= 1'b0;
        q_ofs <= ~16'(o);
        #1;
        chk("ea", 32'(w != 0 ? wr_ea : rd_ea), 32'(e));
        chk("valid", 32'({rd_ea_valid, wr_ea_valid}), 32'(w != 0 ? 1 : 2));
        chk("rev", 32'(wr_rev_used), 32'(rv));
        @(posedge clk_sys);
        #1;
        chk("ptr", 32'(ptr), 32'(v));
        chk("idle", 32'({rd_ea_valid, wr_ea_valid}), 32'h0000_0000);
    endtask
    task automatic report_and_stop();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // ****************
    // tests
    // ****************
    initial begin
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        apb(1'b0, ADDR_CIRC_CTRL, 32'h0000_0000);
        chk("circ", rdat, {16'h0000, CIRC_CTRL_RESET});
        chk("ok", 32'(err), 32'h0000_0000);
        apb(1'b1, ADDR_REV_CTRL, 32'hffff_ffff);
        apb(1'b0, ADDR_REV_CTRL, 32'h0000_0000);
        chk("rev ctrl", rdat, 32'h0000_ffff);
        apb(1'b1, ADDR_STATUS, 32'h0000_0007);
        chk("ro", 32'(err), 32'h0000_0001);
        apb(1'b0, 8'h1c, 32'h0000_0000);
        chk("unmapped", 32'(err), 32'h0000_0001);
        apb(1'b1, ADDR_REV_CTRL, 32'h0000_0000);
        apb(1'b1, ADDR_XMOD_START, 32'h0000_1000); // aligned buffer
        apb(1'b1, ADDR_XMOD_END, 32'h0000_100f);
        apb(1'b1, ADDR_YMOD_START, 32'h0000_2000);
        apb(1'b1, ADDR_YMOD_END, 32'h0000_2007);
        apb(1'b1, ADDR_CIRC_CTRL, 32'h0000_cfc3);
        load(3, 16'h100e);
        load(12, 16'h2006);
        go(0, 3, MBA_AM_PRE_INC, 0, 0, 16'h1000, 16'h1000, 0);
        go(1, 3, MBA_AM_POST_DEC, 0, 0, 16'h1000, 16'h100e, 0);
        go(0, 3, MBA_AM_OFFSET, 6, 0, 16'h1004, 16'h100e, 0);
        go(1, 3, MBA_AM_DIRECT, 0, 0, 16'h100e, 16'h100e, 0);
        go(0, 3, MBA_AM_DIRECT, 0, 0, 16'h100e, 16'h100e, 0);
        go(1, 3, MBA_AM_OFFSET, 2, 0, 16'h1000, 16'h100e, 0);
        go(1, 12, MBA_AM_POST_INC, 0, 1, 16'h2006, 16'h2007, 0);
        go(0, 12, MBA_AM_POST_INC, 0, 1, 16'h2007, 16'h2000, 0);
        apb(1'b1, ADDR_CIRC_CTRL, 32'h0000_8505);
        apb(1'b1, ADDR_REV_CTRL, 32'h0000_8004);
        load(5, 16'h1001);
        // first access after control write is a write
        go(1, 5, MBA_AM_POST_INC, 0, 0, 16'h1000, 16'h1008, 1);
        go(1, 5, MBA_AM_POST_INC, 0, 0, 16'h1008, 16'h1004, 1);
        go(1, 5, MBA_AM_PRE_INC, 0, 0, 16'h100c, 16'h100c, 1);
        go(1, 5, MBA_AM_POST_INC, 0, 0, 16'h100c, 16'h1002, 1);
        apb(1'b0, ADDR_STATUS, 32'h0000_0000);
        chk("status", rdat, 32'h0000_0004);
        load(5, 16'h100e);
        go(0, 5, MBA_AM_POST_INC, 0, 0, 16'h100e, 16'h1000, 0);
        go(1, 5, MBA_AM_POST_INC, 0, 1, 16'h1000, 16'h1001, 0);
        go(1, 5, MBA_AM_POST_DEC, 0, 0, 16'h1001, 16'h100f, 0);
        apb(1'b1, ADDR_REV_CTRL, 32'h0000_c000);
        load(5, 16'h9000);
        go(1, 5, MBA_AM_POST_INC, 0, 0, 16'h9000, 16'h5000, 1);
        apb(1'b1, ADDR_CIRC_CTRL, 32'h0000_0f05);
        load(15, 16'h0800);
        go(1, 15, MBA_AM_POST_INC, 0, 0, 16'h0800, 16'h0802, 0);
        report_and_stop();
    end
    initial begin
        #20_000;
        failures++;
        report_and_stop();
    end
endmodule // tb
